/* logic/lsr_result_regs.sv */
/*
 * Read-only result registers for two ambient light sensor channels.
 * Assumes the serial interface presents one-cycle read and write strobes
 * with an eight-bit address, and the converter gives a count per sensor.
 */
// Functional notes
// R1: First sensor count bits 7..0 read at address 0x40.
// R2: First sensor bits 12..8 in 0x41 field 4..0; bits 7..5 reserved.
// R3: Second sensor uses the same split at 0x42 and 0x43.
// R4: Each result refreshes every 80 ms, only while its sensor is enabled.
// R5: All four result registers are read-only; writes change nothing.
// R6: Host rebuilds count as high field times 0x100 plus low byte.
// R7: Reported count never exceeds 0x1F40, decimal 8000.
// R8: Host scales count over 8000 times the full-scale sensor current.
// R9: Low and high bytes of a sensor update together in one cycle.
`timescale 1ns/1ps
`default_nettype none

module lsr_result_regs #(
   parameter int unsigned REFRESH_CYCLES = lsr_pkg::REFRESH_CYC
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // Register port
   input  wire lsr_pkg::lsr_req_s     i_req,
   output logic                [7:0]  o_rdata,
   output logic                       o_rvalid,
   // Sensor side
   input  wire logic           [1:0]  i_sensor_en,
   input  wire logic      [1:0][12:0] i_conv_count,
   // Refresh strobes
   output logic                [1:0]  o_update
);

   localparam int N = lsr_pkg::N_SENSORS;

   logic [N-1:0][12:0] res;
   logic [7:0]         idx;
   logic               in_map;
   logic               sel_sensor;
   logic               sel_high;
   logic [7:0]         next_rdata;
   lsr_pkg::lsr_result_s sel_res;

   // One capture channel per sensor
   generate
      for (genvar g = 0; g < N; g++)
      begin : g_chan
         lsr_channel #(
            .PERIOD_CYC (REFRESH_CYCLES)
         ) u_chan (
            .i_clk    (i_clk),
            .i_rst    (i_rst),
            .i_en     (i_sensor_en[g]),
            .i_conv   (i_conv_count[g]),
            .o_result (res[g]),
            .o_update (o_update[g])
         );
      end
   endgenerate

   // Address decode: two bytes per sensor from the base
   assign idx        = i_req.addr - lsr_pkg::ADDR_BASE;
   assign in_map     = (i_req.addr >= lsr_pkg::ADDR_BASE) &&
                       (idx < 8'(2 * N));
   assign sel_sensor = idx[1]; // R3
   assign sel_high   = idx[0];
   assign sel_res    = lsr_pkg::lsr_result_s'(res[sel_sensor]);

   // Byte selection with reserved bits forced to zero
   always_comb
   begin
      next_rdata = lsr_pkg::UNMAPPED_VAL;
      if (in_map)
      begin
         if (sel_high)
            next_rdata = {lsr_pkg::RSVD_VAL, sel_res.high}; // R2
         else
            next_rdata = sel_res.low; // R1
      end
   end

   // Registered read answer; writes are taken and dropped
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_rdata  <= lsr_pkg::RDATA_RST;
         o_rvalid <= 1'b0;
      end
      else
      begin
         o_rvalid <= i_req.rd;
         if (i_req.rd)
            o_rdata <= next_rdata; // R5
      end
   end

   // Named read sequences used by the checks below
   sequence s_read(logic [7:0] a);
      i_req.rd && (i_req.addr == a);
   endsequence

   sequence s_answer(logic [7:0] v);
      ##1 (o_rvalid && (o_rdata == v));
   endsequence

   // Expected bytes are taken one cycle back, as seen when the read was
   // taken, so a refresh landing right after the read cannot trip them
   rd_s1_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
      s_read(lsr_pkg::ADDR_S1_LOW) |-> s_answer($past(res[0][7:0]))) // R1
      else $error("sensor 1 low byte read wrong");

   rd_s1_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
      s_read(lsr_pkg::ADDR_S1_HIGH) |->
      s_answer({3'h0, $past(res[0][12:8])})) // R2
      else $error("sensor 1 high byte read wrong");

   rd_s2_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
      s_read(lsr_pkg::ADDR_S2_LOW) |-> s_answer($past(res[1][7:0]))) // R3
      else $error("sensor 2 low byte read wrong");

   rd_s2_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
      s_read(lsr_pkg::ADDR_S2_HIGH) |->
      s_answer({3'h0, $past(res[1][12:8])})) // R3
      else $error("sensor 2 high byte read wrong");

   rd_unmapped_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.rd && !in_map) |=> (o_rvalid && o_rdata == 8'h00))
      else $error("unmapped read not zero");

   // Every taken read gets its answer strobe in the next cycle
   rd_answered_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_req.rd |=> o_rvalid)
      else $error("read without answer");

   // No answer strobe appears without a read behind it
   rvalid_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_req.rd |=> !o_rvalid)
      else $error("read answer without a read");

   // Read data holds between reads, so a slow host still sees it
   rdata_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_req.rd |=> $stable(o_rdata))
      else $error("read data moved without a read");

   // A mapped read of an odd address is a high byte
   sequence s_high_read;
      i_req.rd && in_map && sel_high;
   endsequence

   // Reserved top bits of a high byte always read as zero
   rsvd_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
      s_high_read |=> (o_rdata[7:5] == lsr_pkg::RSVD_VAL)) // R2 R3
      else $error("reserved bits not zero");

   // A lone write gives no answer and leaves the read data alone
   wr_silent_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.wr && !i_req.rd) |=> (!o_rvalid && $stable(o_rdata))) // R5
      else $error("write produced a read answer");

   // Per-sensor checks on write immunity, joint byte update, refresh strobes and stored values
   generate
      for (genvar k = 0; k < N; k++)
      begin : g_chk
         wr_no_effect_a: assert property (@(posedge i_clk)
            disable iff (i_rst)
            (i_req.wr ##1 !o_update[k]) |-> $stable(res[k])) // R5
            else $error("write altered a result register");

         bytes_together_a: assert property (@(posedge i_clk)
            disable iff (i_rst)
            ($changed(res[k][7:0]) || $changed(res[k][12:8])) |->
            o_update[k]) // R9
            else $error("result byte changed outside refresh");

         en_refresh_a: assert property (@(posedge i_clk)
            disable iff (i_rst)
            o_update[k] |-> $past(i_sensor_en[k])) // R4
            else $error("refresh without sensor enabled");

         // A disabled sensor gives no refresh in the next cycle
         off_quiet_a: assert property (@(posedge i_clk)
            disable iff (i_rst)
            !i_sensor_en[k] |=> !o_update[k]) // R4
            else $error("refresh after sensor disabled");

         // Refresh strobe lasts a single cycle
         upd_pulse_a: assert property (@(posedge i_clk)
            disable iff (i_rst)
            o_update[k] |=> !o_update[k]) // R4
            else $error("refresh strobe longer than one cycle");

         // Stored result never beyond full scale at the register face
         res_scale_a: assert property (@(posedge i_clk)
            disable iff (i_rst)
            res[k] <= lsr_pkg::FULL_SCALE) // R7
            else $error("stored result above full scale");

         // A refresh stores the clamped count seen one cycle earlier
         upd_value_a: assert property (@(posedge i_clk)
            disable iff (i_rst)
            o_update[k] |-> res[k] ==
            (($past(i_conv_count[k]) > lsr_pkg::FULL_SCALE) ?
             lsr_pkg::FULL_SCALE : $past(i_conv_count[k]))) // R4 R7
            else $error("refresh stored a wrong count");
      end
   endgenerate

endmodule : lsr_result_regs

`default_nettype wire

/* logic/lsr_pkg.sv */
/*
 * Shared constants and carriers for the light sensor result registers.
 * Assumes a single 200 MHz device clock and an eight-bit register port
 * driven by the device's serial programming interface.
 */
`default_nettype none

package lsr_pkg;

   // Register map
   localparam logic [7:0] ADDR_S1_LOW   = 8'h40;
   localparam logic [7:0] ADDR_S1_HIGH  = 8'h41;
   localparam logic [7:0] ADDR_S2_LOW   = 8'h42;
   localparam logic [7:0] ADDR_S2_HIGH  = 8'h43;
   localparam logic [7:0] ADDR_BASE     = ADDR_S1_LOW;

   // Field layout
   localparam int         N_SENSORS     = 2;
   localparam int         COUNT_W       = 13;
   localparam int         LOW_W         = 8;
   localparam int         HIGH_W        = 5;
   localparam int         RSVD_W        = 3;
   localparam int         HIGH_LSB      = 8;

   // Values
   localparam logic [12:0] FULL_SCALE   = 13'h1F40;
   localparam logic [12:0] RESULT_RST   = 13'h0000;
   localparam logic [7:0]  RDATA_RST    = 8'h00;
   localparam logic [7:0]  UNMAPPED_VAL = 8'h00;
   localparam logic [2:0]  RSVD_VAL     = 3'h0;

   // Timing
   localparam int         REFRESH_MS    = 80;
   localparam int         CLK_MHZ       = 200;
   localparam int         REFRESH_CYC   = REFRESH_MS * 1000 * CLK_MHZ;

   // One register port request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lsr_req_s;

   // A conversion result split into its two bytes
   typedef struct packed {
      logic [4:0] high;
      logic [7:0] low;
   } lsr_result_s;

endpackage : lsr_pkg

`default_nettype wire

/* logic/lsr_channel.sv */
/*
 * One sensor channel: an 80 ms refresh timer that captures the converter
 * count while the sensor is enabled, clamped to full scale.
 * Assumes i_conv is the converter's latest count, synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module lsr_channel #(
   parameter int unsigned PERIOD_CYC = lsr_pkg::REFRESH_CYC
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Sensor side
   input  wire logic        i_en,
   input  wire logic [12:0] i_conv,
   // Result
   output logic      [12:0] o_result,
   output logic             o_update
);

   localparam int          CW   = $clog2(PERIOD_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);

   logic [CW-1:0] tick;
   logic [12:0]   next_result;
   logic          fire;

   // Refresh timer, held at zero while the sensor is off
   always_ff @(posedge i_clk)
   begin
      if (i_rst || !i_en)
         tick <= '0;
      else if (tick == LAST)
         tick <= '0;
      else
         tick <= tick + 1'b1;
   end

   assign fire = i_en && (tick == LAST); // R4

   // Clamp so the count never passes full scale
   assign next_result = (i_conv > lsr_pkg::FULL_SCALE) ?
                        lsr_pkg::FULL_SCALE : i_conv; // R7

   // Whole 13-bit result captured in one edge
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_result <= lsr_pkg::RESULT_RST;
         o_update <= 1'b0;
      end
      else
      begin
         o_update <= fire;
         if (fire)
            o_result <= next_result; // R9
      end
   end

   // Helper: cycles since enable or since the last refresh
   int unsigned gap;
   always_ff @(posedge i_clk)
   begin
      if (i_rst || !i_en)
         gap <= 0;
      else if (o_update)
         gap <= 1;
      else
         gap <= gap + 1;
   end

   refresh_period_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_update |-> gap == PERIOD_CYC) // R4
      else $error("refresh not on its period");

   off_no_refresh_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_en |=> !o_update) // R4
      else $error("refresh while sensor disabled");

   clamp_scale_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_result <= lsr_pkg::FULL_SCALE) // R7
      else $error("result above full scale");

endmodule : lsr_channel

`default_nettype wire

/* bench/lsr_sensor_model.sv */
/*
 * Sensor-side model: a converter count for each of the two channels.
 * Assumes the result block pulses i_update when it has taken a count.
 */
`timescale 1ns/1ps
`default_nettype none

module lsr_sensor_model (
   // Clock and capture strobes
   input  wire logic             i_clk,
   input  wire logic [1:0]       i_update,
   // Converter counts
   output logic      [1:0][12:0] o_conv
);
   integer seed = 74249;

   initial o_conv = '0;

   // New counts after each capture; channel 0 sits near full scale
   always @(posedge i_clk)
      if (|i_update)
      begin
         o_conv[0] <= 13'($random(seed)) | 13'h1E00;
         o_conv[1] <= 13'($random(seed));
      end
endmodule : lsr_sensor_model

`default_nettype wire

/* bench/lsr_result_regs_test.sv */
/*
 * Self-checking bench for the light sensor result registers.
 * Assumes the sensor model in this folder and a shortened refresh period.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module lsr_result_regs_test;
   localparam int P = 16;
   // Edges spent after a strobe by wait_upd's tail plus read_all
   localparam int RD_EDGES = 7;
   // Full-scale sensor current in arbitrary units for the host scaling
   localparam int FS_CUR = 1000;
   logic [7:0]        exp_b;
   logic [7:0]        low_b = 8'h00;
   int                raw;
   int                ans = 0;
   logic              i_clk = 1'b0;
   logic              i_rst = 1'b1;
   lsr_pkg::lsr_req_s req   = '0;
   logic [1:0]        en    = 2'h0;
   logic [7:0]        o_rdata;
   logic              o_rvalid;
   logic [1:0]        o_update;
   logic [1:0][12:0]  conv;
   logic [1:0][12:0]  res   = '0;
   logic [7:0]        exp_q[$];
   integer            seed  = 74249;
   int                error_cnt = 0;
   int                compares  = 0;
   int                cyc = 0;
   int                n;

   lsr_result_regs #(.REFRESH_CYCLES(P)) DUT (
      .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_rdata(o_rdata),
      .o_rvalid(o_rvalid), .i_sensor_en(en), .i_conv_count(conv),
      .o_update(o_update));
   lsr_sensor_model model (.i_clk(i_clk), .i_update(o_update),
      .o_conv(conv));

   initial forever #2.5 i_clk = ~i_clk;

   // Expected capture, clamped to full scale
   function automatic logic [12:0] clamp(input logic [12:0] c);
      return (c > 13'h1F40) ? 13'h1F40 : c;
   endfunction : clamp

   // Reads all four results and one unmapped place, random writes alongside
   task automatic read_all;
      for (int a = 0; a < 5; a++)
      begin
         @(posedge i_clk);
         req.rd    <= 1'b1;
         req.wr    <= 1'($random(seed));
         req.wdata <= 8'($random(seed));
         req.addr  <= lsr_pkg::ADDR_BASE + 8'(a);
         exp_q.push_back(a == 4 ? 8'h00 : a[0] ? {3'h0, res[a/2][12:8]}
            : res[a/2][7:0]);
      end
      @(posedge i_clk);
      req.rd <= 1'b0;
   endtask : read_all

   // Waits for a refresh strobe, counting edges
   task automatic wait_upd(output int cnt);
      cnt = 0;
      do
      begin
         @(posedge i_clk);
         #1;
         cnt++;
      end while (!(|o_update) && cnt < 100);
      @(posedge i_clk);
   endtask : wait_upd

   task automatic complete_run;
      if (error_cnt == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // Answers against notes; results follow strobes of enabled sensors
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         error_cnt++;
         complete_run;
      end
      if (o_rvalid && exp_q.size() > 0)
      begin
         exp_b = exp_q.pop_front();
         `CHK(o_rdata, exp_b)
         // Host rebuilds each count from its byte pair and scales it
         if (ans % 5 == 0 || ans % 5 == 2)
            low_b = o_rdata;
         else if (ans % 5 != 4)
         begin
            raw = int'(o_rdata) * 'h100 + int'(low_b);
            `CHK(raw, int'(res[(ans % 5) / 2]))
            `CHK((raw * FS_CUR / 8000) <= FS_CUR, 1'b1)
         end
         ans++;
      end
      for (int k = 0; k < 2; k++)
         if (o_update[k] && en[k])
            res[k] <= clamp(conv[k]);
   end

   // Reset, first period, refresh runs, then each sensor frozen in turn
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      read_all;
      @(posedge i_clk);
      en <= 2'h3;
      wait_upd(n);
      `CHK(n, P)
      read_all;
      repeat (4)
      begin
         wait_upd(n);
         `CHK(n + RD_EDGES, P)
         read_all;
      end
      en <= 2'h1;
      repeat (3)
      begin
         wait_upd(n);
         read_all;
      end
      en <= 2'h0;
      repeat (30) @(posedge i_clk);
      read_all;
      repeat (8) @(posedge i_clk);
      complete_run;
   end
endmodule : lsr_result_regs_test

`default_nettype wire
